// ===== logic/ptp_rx_cfg.svh
// register offsets, field positions and reset values for the ptp receive filter and capture block
`ifndef PTP_RX_CFG_SVH
`define PTP_RX_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_BANK_SELECT 12'h100
`define OFS_CAPTURE_STATUS 12'h104
`define OFS_FILTER_MATCH 12'h108
`define OFS_FILTER_CONFIG 12'h168
`define OFS_CAPTURE_SECONDS 12'h16c
`define OFS_CAPTURE_NANOSECONDS 12'h170
`define OFS_CAPTURE_HEADER 12'h174
`define OFS_PDREQ_SECONDS 12'h178
`define OFS_PDREQ_NANOSECONDS 12'h17c
`define OFS_PDREQ_CORR_HIGH 12'h180
`define OFS_PDREQ_CORR_LOW 12'h184
`define OFS_FILTER_DROP_COUNT 12'h18c
// ----------------------------------------
// fields and constants
// ----------------------------------------
`define THIS_PORT_BANK 3'h1
`define BIT_ALT_LEADER_EN 18
`define BIT_DOMAIN_EN 17
`define BIT_VERSION_EN 16
`define BIT_AUTO_UPDATE 31
`define MSG_KIND_PDELAY_REQ 4'h2
`define CAPTURE_DEPTH 3'h4
`define CRC12_POLY 12'h80f
`define CRC12_SEED 12'hfff
`define COUNT_MAX 32'hffffffff
`define ZERO_WORD 32'h00000000
`endif

// ===== logic/ptp_rx_filter_timestamp_capture.sv
// ptp receive message filter, timestamp capture buffer and peer-delay holding registers
//
// Operation
// - alternate leader enable drops messages whose alternate leader flag is set
// - domain enable drops messages whose domain differs from programmed domain
// - version enable drops messages whose version differs from programmed version
// - sixteen message kind filter enables, reset to zero
// - enable bit n filters message kind n
// - up to four captures of ingress time and header are buffered
// - capture values valid only while capture count is nonzero
// - capture seconds is 32-bit read-only, reset zero
// - capture nanoseconds in bits 29:0, bits 31:30 reserved
// - 12-bit checksum of source identity reported in header bits 31:20
// - message kind reported in header bits 19:16
// - sequence number reported in header bits 15:0
// - peer-delay request seconds keeps low four bits, read and write
// - auto update loads peer-delay time and correction on each request
// - port registers answer only when bank select names this port
// - correction held as upper 32 bits and next 16 bits, low 16 reserved
// - filtered packets increment saturating counter, cleared by zero write, flag mac error
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "ptp_rx_cfg.svh"

module ptp_rx_filter_timestamp_capture
  import ptp_rx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // ingress message stream and time of day
  input wire logic msg_valid_i,
  input wire ptp_msg_t msg_i,
  input wire tod_t tod_i,
  // filter results
  output logic msg_drop_o,
  output logic mac_error_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [2:0] bank_select;
  logic [7:0] match_domain;
  logic [3:0] match_version;
  logic [31:0] filter_config;
  logic [15:0] message_kind_filter_enables;
  logic [3:0] pdreq_seconds;
  logic [29:0] pdreq_nanoseconds;
  logic auto_update;
  logic [31:0] pdreq_corr_high;
  logic [15:0] pdreq_corr_low;
  logic [31:0] filter_drop_counter;
  capture_t capture_mem [0:3];
  logic [1:0] read_ptr;
  logic [1:0] write_ptr;
  logic [2:0] rx_capture_count;
  logic bus_req;
  logic bus_write;
  logic bus_read;
  logic bank_hit;
  logic drop_now;
  logic accept_now;
  logic push;
  logic pop;
  logic [31:0] next_rdata;
  logic [11:0] next_checksum;
  capture_t head;

  assign message_kind_filter_enables = filter_config[15:0];
  assign head = capture_mem[read_ptr];

  // ----------------------------------------
  // source identity checksum
  // ----------------------------------------
  function automatic logic [11:0] crc12(input logic [79:0] data);
    logic [11:0] crc;
    logic fb;
    crc = `CRC12_SEED;
    for (int i = 79; i >= 0; i--) begin
      fb = crc[11] ^ data[i];
      crc = {crc[10:0], 1'b0};
      if (fb) begin
        crc = crc ^ `CRC12_POLY;
      end
    end
    return crc;
  endfunction

  assign next_checksum = crc12(msg_i.source_identity);

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  // one request per ack; the ack cycle itself is not a new request
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_req && wb_we_i && (wb_sel_i == 4'hf);
  assign bus_read = bus_req && !wb_we_i;
  assign bank_hit = (bank_select == `THIS_PORT_BANK);

  // ----------------------------------------
  // message filter
  // ----------------------------------------
  always_comb begin
    drop_now = 1'b0;
    if (message_kind_filter_enables[msg_i.message_kind]) begin
      drop_now = 1'b1;
    end else if (filter_config[`BIT_ALT_LEADER_EN] && msg_i.alternate_leader) begin
      drop_now = 1'b1;
    end else if (filter_config[`BIT_DOMAIN_EN] && (msg_i.domain != match_domain)) begin
      drop_now = 1'b1;
    end else if (filter_config[`BIT_VERSION_EN] && (msg_i.version != match_version)) begin
      drop_now = 1'b1;
    end
  end

  assign accept_now = msg_valid_i && !drop_now;
  // a full buffer with no header read in the same cycle keeps its oldest captures and discards the newcomer
  assign push = accept_now && (rx_capture_count != `CAPTURE_DEPTH || pop);
  assign pop = bus_read && bank_hit && (wb_adr_i == `OFS_CAPTURE_HEADER) && (rx_capture_count != 3'h0);

  // drop and mac error pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_drop_o <= 1'b0;
      mac_error_o <= 1'b0;
    end else begin
      msg_drop_o <= msg_valid_i && drop_now;
      mac_error_o <= msg_valid_i && drop_now;
    end
  end

  // ----------------------------------------
  // software control registers
  // ----------------------------------------
  // bank select sits outside the banked space
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_select <= 3'h0;
    end else if (bus_write && wb_adr_i == `OFS_BANK_SELECT) begin
      bank_select <= wb_dat_i[2:0];
    end
  end

  // filter configuration and match values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_config <= `ZERO_WORD;
      match_domain <= 8'h00;
      match_version <= 4'h0;
    end else if (bus_write && bank_hit) begin
      if (wb_adr_i == `OFS_FILTER_CONFIG) begin
        filter_config <= {13'h0000, wb_dat_i[18:0]};
      end else if (wb_adr_i == `OFS_FILTER_MATCH) begin
        match_domain <= wb_dat_i[7:0];
        match_version <= wb_dat_i[11:8];
      end
    end
  end

  // ----------------------------------------
  // peer-delay holding registers
  // ----------------------------------------
  // hardware load wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdreq_seconds <= 4'h0;
      pdreq_nanoseconds <= 30'h00000000;
      pdreq_corr_high <= `ZERO_WORD;
      pdreq_corr_low <= 16'h0000;
    end else if (msg_valid_i && auto_update && msg_i.message_kind == `MSG_KIND_PDELAY_REQ) begin
      pdreq_seconds <= tod_i.seconds[3:0];
      pdreq_nanoseconds <= tod_i.nanoseconds;
      pdreq_corr_high <= msg_i.correction_value[63:32];
      pdreq_corr_low <= msg_i.correction_value[31:16];
    end else if (bus_write && bank_hit) begin
      if (wb_adr_i == `OFS_PDREQ_SECONDS) begin
        pdreq_seconds <= wb_dat_i[3:0];
      end else if (wb_adr_i == `OFS_PDREQ_NANOSECONDS) begin
        pdreq_nanoseconds <= wb_dat_i[29:0];
      end else if (wb_adr_i == `OFS_PDREQ_CORR_HIGH) begin
        pdreq_corr_high <= wb_dat_i;
      end else if (wb_adr_i == `OFS_PDREQ_CORR_LOW) begin
        pdreq_corr_low <= wb_dat_i[31:16];
      end
    end
  end

  // auto update bit, software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_update <= 1'b0;
    end else if (bus_write && bank_hit && wb_adr_i == `OFS_PDREQ_NANOSECONDS) begin
      auto_update <= wb_dat_i[`BIT_AUTO_UPDATE];
    end
  end

  // ----------------------------------------
  // filtered packet counter
  // ----------------------------------------
  // a drop in the cycle of a zero write still counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_drop_counter <= `ZERO_WORD;
    end else if (bus_write && bank_hit && wb_adr_i == `OFS_FILTER_DROP_COUNT && wb_dat_i == `ZERO_WORD) begin
      filter_drop_counter <= {31'h00000000, msg_valid_i && drop_now};
    end else if (msg_valid_i && drop_now && filter_drop_counter != `COUNT_MAX) begin
      filter_drop_counter <= filter_drop_counter + 32'h00000001;
    end
  end

  // ----------------------------------------
  // capture buffer
  // ----------------------------------------
  // storage written at the write pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        capture_mem[i] <= '0;
      end
    end else if (push) begin
      capture_mem[write_ptr] <= '{capture_seconds: tod_i.seconds,
                                 capture_nanoseconds: tod_i.nanoseconds,
                                 source_identity_checksum: next_checksum,
                                 message_kind: msg_i.message_kind,
                                 sequence_number: msg_i.sequence_number};
    end
  end

  // pointers and count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_ptr <= 2'h0;
      read_ptr <= 2'h0;
      rx_capture_count <= 3'h0;
    end else begin
      if (push) begin
        write_ptr <= write_ptr + 2'h1;
      end
      if (pop) begin
        read_ptr <= read_ptr + 2'h1;
      end
      if (push && !pop) begin
        rx_capture_count <= rx_capture_count + 3'h1;
      end else if (pop && !push) begin
        rx_capture_count <= rx_capture_count - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // read data and ack
  // ----------------------------------------
  // read mux; unmapped or other-bank words read zero
  always_comb begin
    next_rdata = `ZERO_WORD;
    if (wb_adr_i == `OFS_BANK_SELECT) begin
      next_rdata = {29'h00000000, bank_select};
    end else if (!bank_hit) begin
      next_rdata = `ZERO_WORD;
    end else if (wb_adr_i == `OFS_CAPTURE_STATUS) begin
      next_rdata = {29'h00000000, rx_capture_count};
    end else if (wb_adr_i == `OFS_FILTER_MATCH) begin
      next_rdata = {20'h00000, match_version, match_domain};
    end else if (wb_adr_i == `OFS_FILTER_CONFIG) begin
      next_rdata = filter_config;
    end else if (wb_adr_i == `OFS_CAPTURE_SECONDS) begin
      next_rdata = head.capture_seconds;
    end else if (wb_adr_i == `OFS_CAPTURE_NANOSECONDS) begin
      next_rdata = {2'h0, head.capture_nanoseconds};
    end else if (wb_adr_i == `OFS_CAPTURE_HEADER) begin
      next_rdata = {head.source_identity_checksum, head.message_kind, head.sequence_number};
    end else if (wb_adr_i == `OFS_PDREQ_SECONDS) begin
      next_rdata = {28'h0000000, pdreq_seconds};
    end else if (wb_adr_i == `OFS_PDREQ_NANOSECONDS) begin
      next_rdata = {auto_update, 1'b0, pdreq_nanoseconds};
    end else if (wb_adr_i == `OFS_PDREQ_CORR_HIGH) begin
      next_rdata = pdreq_corr_high;
    end else if (wb_adr_i == `OFS_PDREQ_CORR_LOW) begin
      next_rdata = {pdreq_corr_low, 16'h0000};
    end else if (wb_adr_i == `OFS_FILTER_DROP_COUNT) begin
      next_rdata = filter_drop_counter;
    end
  end

  // ack one cycle after the request, data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `ZERO_WORD;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_read) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pdreq_seen;
    msg_valid_i && auto_update && msg_i.message_kind == `MSG_KIND_PDELAY_REQ;
  endsequence

  sequence s_header_read;
    pop && !push;
  endsequence

  sequence s_capture_taken;
    push && !pop;
  endsequence

  sequence s_drop_clear;
    bus_write && bank_hit && wb_adr_i == `OFS_FILTER_DROP_COUNT && wb_dat_i == `ZERO_WORD && !(msg_valid_i && drop_now);
  endsequence

  a_alt_leader_drop: assert property (
    msg_valid_i && filter_config[`BIT_ALT_LEADER_EN] && msg_i.alternate_leader |=> msg_drop_o)
    else $error("alternate leader message not dropped");
  a_domain_drop: assert property (
    msg_valid_i && filter_config[`BIT_DOMAIN_EN] && msg_i.domain != match_domain |=> msg_drop_o && mac_error_o)
    else $error("foreign domain message not dropped");
  a_version_drop: assert property (
    msg_valid_i && filter_config[`BIT_VERSION_EN] && msg_i.version != match_version |=> msg_drop_o)
    else $error("wrong version message not dropped");
  a_kind_pass: assert property (
    msg_valid_i && filter_config[18:0] == 19'h00000 |=> !msg_drop_o)
    else $error("message dropped with all filters off");
  a_buffer_bound: assert property (rx_capture_count <= `CAPTURE_DEPTH)
    else $error("capture count above depth");
  a_count_pop: assert property (s_header_read |=> rx_capture_count == $past(rx_capture_count) - 3'h1)
    else $error("header read did not advance buffer");
  a_pdreq_load: assert property (
    s_pdreq_seen |=> pdreq_nanoseconds == $past(tod_i.nanoseconds) && pdreq_seconds == $past(tod_i.seconds[3:0]))
    else $error("peer delay time not loaded");
  a_pdreq_hold: assert property (
    !auto_update && !bus_write |=> $stable(pdreq_nanoseconds) && $stable(pdreq_corr_high))
    else $error("peer delay registers changed without cause");
  a_drop_count: assert property (
    msg_valid_i && drop_now && !bus_write && filter_drop_counter != `COUNT_MAX
    |=> filter_drop_counter == $past(filter_drop_counter) + 32'h00000001)
    else $error("drop counter did not advance");
  a_bus_ack: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");
  // buffer fill, refusal when full, counter clear, drop pulse, bank and byte-select guards, correction load
  a_push_count: assert property (s_capture_taken |=> rx_capture_count == $past(rx_capture_count) + 3'h1)
    else $error("accepted message not counted");
  a_full_refuse: assert property (
    accept_now && rx_capture_count == `CAPTURE_DEPTH && !pop |=> rx_capture_count == `CAPTURE_DEPTH && $stable(write_ptr))
    else $error("full buffer took a new capture");
  a_drop_clear: assert property (s_drop_clear |=> filter_drop_counter == `ZERO_WORD)
    else $error("drop counter not cleared");
  a_drop_pulse: assert property (!msg_valid_i |=> !msg_drop_o && !mac_error_o)
    else $error("drop pulse without message");
  a_bank_miss: assert property (
    bus_write && !bank_hit && wb_adr_i != `OFS_BANK_SELECT |=> $stable(filter_config) && $stable(auto_update))
    else $error("write reached unselected bank");
  a_partial_sel: assert property (
    bus_req && wb_we_i && wb_sel_i != 4'hf |=> $stable(filter_config) && $stable(bank_select))
    else $error("partial write took effect");
  a_pdreq_corr: assert property (
    s_pdreq_seen |=> pdreq_corr_high == $past(msg_i.correction_value[63:32])
      && pdreq_corr_low == $past(msg_i.correction_value[31:16]))
    else $error("peer delay correction not loaded");

endmodule

// ===== logic/ptp_rx_pkg.sv
// types shared by the ptp receive filter and capture block
package ptp_rx_pkg;
  // one parsed ptp message from the ingress port
  typedef struct packed {
    logic [3:0] message_kind;
    logic [3:0] version;
    logic [7:0] domain;
    logic alternate_leader;
    logic [15:0] sequence_number;
    logic [79:0] source_identity;
    logic [63:0] correction_value;
  } ptp_msg_t;
  // time-of-day counter value
  typedef struct packed {
    logic [31:0] seconds;
    logic [29:0] nanoseconds;
  } tod_t;
  // one buffered receive capture
  typedef struct packed {
    logic [31:0] capture_seconds;
    logic [29:0] capture_nanoseconds;
    logic [11:0] source_identity_checksum;
    logic [3:0] message_kind;
    logic [15:0] sequence_number;
  } capture_t;
endpackage

// ===== tb/ptp_rx_filter_timestamp_capture_tb.sv
// self-checking bench for the ptp receive filter and capture block
`timescale 1ns/100ps
`include "ptp_rx_cfg.svh"
module ptp_rx_filter_timestamp_capture_tb
  import ptp_rx_pkg::*;
;
  typedef struct {string name; logic [31:0] val;} note_t;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, msg_valid_i, msg_drop_o, mac_error_o;
  logic [11:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0, wb_dat_o, seed = 32'h801d;
  ptp_msg_t msg_i, m;
  tod_t tod_i, last_t;
  note_t rd_q[$], nt;
  logic drop_q[$], valid_d = 0, d;
  capture_t cap_q[$], c;
  int fail_count = 0, check_count = 0;
  ptp_rx_filter_timestamp_capture i_ptp_rx_filter_timestamp_capture (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .msg_valid_i(msg_valid_i), .msg_i(msg_i),
    .tod_i(tod_i), .msg_drop_o(msg_drop_o), .mac_error_o(mac_error_o));
  ptp_rx_port_model i_ptp_rx_port_model (.clk_i(clk_i), .msg_valid_o(msg_valid_i), .msg_o(msg_i), .tod_o(tod_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [11:0] crc12(input logic [79:0] x);
    logic [11:0] r;
    r = `CRC12_SEED;
    for (int i = 79; i >= 0; i--) r = {r[10:0], 1'b0} ^ ((r[11] ^ x[i]) ? `CRC12_POLY : 12'h000);
    return r;
  endfunction
  function automatic ptp_msg_t rnd_msg(input logic [3:0] k);
    ptp_msg_t x;
    x.message_kind = k;
    x.version = 4'h2;
    x.domain = 8'h05;
    x.alternate_leader = 1'b0;
    x.sequence_number = 16'(rnd());
    x.source_identity = {rnd(), rnd(), 16'(rnd())};
    x.correction_value = {rnd(), rnd()};
    return x;
  endfunction
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] x);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= x;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    rd_q.push_back('{n, e});
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic rd_cap();
    c = cap_q.pop_front();
    rd(`OFS_CAPTURE_SECONDS, c.capture_seconds, "seconds");
    rd(`OFS_CAPTURE_NANOSECONDS, {2'b00, c.capture_nanoseconds}, "nanoseconds");
    rd(`OFS_CAPTURE_HEADER, {c.source_identity_checksum, c.message_kind, c.sequence_number}, "header");
  endtask
  task automatic send(input ptp_msg_t x, input logic drop);
    tod_t t;
    t.seconds = rnd();
    t.nanoseconds = 30'(rnd());
    last_t = t;
    drop_q.push_back(drop);
    if (!drop && cap_q.size() < 4) cap_q.push_back('{t.seconds, t.nanoseconds, crc12(x.source_identity),
      x.message_kind, x.sequence_number});
    i_ptp_rx_port_model.send(x, t);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // output monitors
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
      nt = rd_q.pop_front();
      check(nt.name, nt.val, wb_dat_o);
    end
    if (valid_d && drop_q.size() > 0) begin
      d = drop_q.pop_front();
      check("msg_drop_o", {31'h0, d}, {31'h0, msg_drop_o});
      check("mac_error_o", {31'h0, d}, {31'h0, mac_error_o});
    end
    valid_d <= msg_valid_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(`OFS_FILTER_CONFIG, 1'b1, 32'hffff);
    rd(`OFS_BANK_SELECT, 32'h0, "bank_select");
    bus(`OFS_BANK_SELECT, 1'b1, {29'h0, `THIS_PORT_BANK});
    wb_sel_i <= 4'h3;
    bus(`OFS_FILTER_CONFIG, 1'b1, 32'h1);
    wb_sel_i <= 4'hf;
    rd(`OFS_FILTER_CONFIG, 32'h0, "filter_config");
    rd(`OFS_CAPTURE_SECONDS, 32'h0, "seconds");
    rd(`OFS_PDREQ_SECONDS, 32'h0, "pdreq_seconds");
    rd(`OFS_FILTER_DROP_COUNT, 32'h0, "drop_count");
    rd(12'h1f0, 32'h0, "unmapped");
    bus(`OFS_FILTER_MATCH, 1'b1, 32'h0205);
    rd(`OFS_FILTER_MATCH, 32'h0205, "filter_match");
    $display("test reset done");
    for (int i = 0; i < 5; i++) send(rnd_msg(4'(i * 3)), 1'b0);
    rd(`OFS_CAPTURE_STATUS, 32'h4, "capture_count");
    repeat (4) rd_cap();
    rd(`OFS_CAPTURE_STATUS, 32'h0, "capture_count");
    $display("test capture done");
    for (int k = 0; k < 16; k++) begin
      bus(`OFS_FILTER_CONFIG, 1'b1, 32'h1 << k);
      send(rnd_msg(4'(k)), 1'b1);
    end
    bus(`OFS_FILTER_CONFIG, 1'b1, 32'h7 << 16);
    for (int j = 0; j < 4; j++) begin
      m = rnd_msg(4'h5);
      if (j == 0) m.version = 4'h3;
      if (j == 1) m.domain = 8'h06;
      if (j == 2) m.alternate_leader = 1'b1;
      send(m, j < 3);
    end
    rd(`OFS_FILTER_DROP_COUNT, 32'd19, "drop_count");
    bus(`OFS_FILTER_DROP_COUNT, 1'b1, 32'h0);
    rd(`OFS_FILTER_DROP_COUNT, 32'h0, "drop_count");
    rd_cap();
    $display("test filter done");
    bus(`OFS_FILTER_CONFIG, 1'b1, 32'h0202);
    send(rnd_msg(4'h1), 1'b1);
    send(rnd_msg(4'h9), 1'b1);
    rd(`OFS_FILTER_DROP_COUNT, 32'h2, "drop_count");
    bus(`OFS_PDREQ_NANOSECONDS, 1'b1, 32'h80000000);
    m = rnd_msg(`MSG_KIND_PDELAY_REQ);
    send(m, 1'b0);
    rd(`OFS_PDREQ_SECONDS, {28'h0, last_t.seconds[3:0]}, "pdreq_seconds");
    rd(`OFS_PDREQ_NANOSECONDS, {2'b10, last_t.nanoseconds}, "pdreq_nanoseconds");
    rd(`OFS_PDREQ_CORR_HIGH, m.correction_value[63:32], "corr_high");
    rd(`OFS_PDREQ_CORR_LOW, {m.correction_value[31:16], 16'h0}, "corr_low");
    bus(`OFS_PDREQ_NANOSECONDS, 1'b1, 32'h1234);
    bus(`OFS_PDREQ_SECONDS, 1'b1, 32'h1a);
    send(rnd_msg(`MSG_KIND_PDELAY_REQ), 1'b0);
    rd(`OFS_PDREQ_SECONDS, 32'ha, "pdreq_seconds");
    rd(`OFS_PDREQ_NANOSECONDS, 32'h1234, "pdreq_nanoseconds");
    repeat (2) rd_cap();
    $display("test peer_delay done");
    @(posedge clk_i);
    wrap_up();
  end
endmodule

// ===== tb/ptp_rx_port_model.sv
// ingress port model delivering parsed ptp messages with their ingress time
`timescale 1ns/100ps
module ptp_rx_port_model
  import ptp_rx_pkg::*;
(
  // clock
  input wire logic clk_i,
  // message stream and time of day
  output logic msg_valid_o,
  output ptp_msg_t msg_o,
  output tod_t tod_o
);
  initial begin
    msg_valid_o = 1'b0;
    msg_o = '0;
    tod_o = '0;
  end
  // one message for one cycle; lines scrambled once released
  task automatic send(input ptp_msg_t m, input tod_t t);
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_o <= m;
    tod_o <= t;
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_o <= ~m;
    tod_o <= ~t;
  endtask
endmodule
